// *** core/slc_link_ctrl.sv ***
// Added by the designer: the Avalon-MM slave port.
`default_nettype none
module slc_link_ctrl #(
	parameter int LINKS = slc_pkg::LINKS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [slc_pkg::AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// link receiver events
	input wire logic [LINKS-1:0] rx_overflow_i,
	input wire logic [LINKS-1:0] rx_bad_token_i,
	input wire logic [LINKS-1:0] credit_issued_i,
	input wire logic [LINKS-1:0] credit_recv_i,
	// link transmitter events
	input wire logic [LINKS-1:0] tx_sym_i,
	input wire logic [LINKS-1:0] tx_tok_end_i,
	// link controls
	output logic [LINKS-1:0] link_en_o,
	output logic [LINKS-1:0] pin_to_link_o,
	output logic [LINKS-1:0] wide_mode_o,
	output logic [LINKS-1:0] greeting_o,
	output logic [LINKS-1:0] rx_reset_o,
	output logic [LINKS-1:0] tx_ready_o,
	// static forwarding, indexed by link a..h
	output logic [LINKS-1:0] fwd_en_o,
	output logic [LINKS-1:0] fwd_proc_o,
	output logic [LINKS*slc_pkg::CHAN_W-1:0] fwd_chanend_o,
	// interrupt
	output logic irq_o
);
	localparam int GW = slc_pkg::GAP_W;
	localparam int CW = slc_pkg::CHAN_W;

	// forwarding register k serves link k xor 2 (c,d,a,b,g,h,e,f)
	function automatic int fwd_link(input int k);
		fwd_link = k ^ 2;
	endfunction

	// byte-lane merge of a write onto an old value
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		merge = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				merge[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
	endfunction

	// byte-lane merge of a gap field that sits at bit lo of the word
	function automatic logic [GW-1:0] gap_merge(input logic [GW-1:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be, input int lo);
		gap_merge = old_v;
		for (int j = 0; j < GW; j++) begin
			if (be[(lo + j) / 8]) begin
				gap_merge[j] = new_v[lo + j];
			end
		end
	endfunction

	// bus handshake: one wait cycle, then accept
	logic req;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic [31:0] wdata;
	assign req = avs_read_i | avs_write_i;
	assign acc = req & ~avs_waitrequest_o;
	assign wr_acc = acc & avs_write_i;
	assign rd_acc = acc & avs_read_i;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
		end
	end

	// per-link control state
	logic [LINKS-1:0] en_reg;
	logic [LINKS-1:0] wide_reg;
	logic [LINKS-1:0] err_reg;
	logic [LINKS-1:0] given_reg;
	logic [LINKS-1:0] hold_reg;
	logic [GW-1:0] sym_gap_reg [LINKS];
	logic [GW-1:0] tok_gap_reg [LINKS];
	logic [LINKS-1:0] fwd_en_reg;
	logic [LINKS-1:0] fwd_proc_reg;
	logic [CW-1:0] fwd_chan_reg [LINKS];
	logic [15:0] irq_stat_reg;
	logic [15:0] irq_mask_reg;

	// write strobes decoded per link
	logic [LINKS-1:0] ctrl_wr;
	logic [LINKS-1:0] fwd_wr;
	logic [LINKS-1:0] greet_wr;
	logic [LINKS-1:0] rxrst_wr;
	always_comb begin
		wdata = merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
		for (int i = 0; i < LINKS; i++) begin
			ctrl_wr[i] = wr_acc &&
				(avs_address_i == slc_pkg::CTRL_BASE + 8'(i));
			fwd_wr[i] = wr_acc &&
				(avs_address_i == slc_pkg::FWD_BASE + 8'(fwd_link(i)));
			greet_wr[i] = ctrl_wr[i] && avs_byteenable_i[3] &&
				wdata[slc_pkg::GREET_BIT];
			rxrst_wr[i] = ctrl_wr[i] && avs_byteenable_i[2] &&
				wdata[slc_pkg::RXRST_BIT];
		end
	end

	// writable control fields, reserved bits are never stored
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_reg <= '0;
			wide_reg <= '0;
			for (int i = 0; i < LINKS; i++) begin
				sym_gap_reg[i] <= slc_pkg::GAP_RST;
				tok_gap_reg[i] <= slc_pkg::GAP_RST;
			end
		end else begin
			for (int i = 0; i < LINKS; i++) begin
				if (ctrl_wr[i]) begin
					if (avs_byteenable_i[3]) begin
						en_reg[i] <= wdata[slc_pkg::EN_BIT];
						wide_reg[i] <= wdata[slc_pkg::WIDE_BIT];
					end
					sym_gap_reg[i] <= gap_merge(sym_gap_reg[i],
						avs_writedata_i, avs_byteenable_i, slc_pkg::SYM_LO);
					tok_gap_reg[i] <= gap_merge(tok_gap_reg[i],
						avs_writedata_i, avs_byteenable_i, slc_pkg::TOK_LO);
				end
			end
		end
	end

	// sticky receive error, cleared by receiver reset, event wins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			err_reg <= '0;
		end else begin
			for (int i = 0; i < LINKS; i++) begin
				if (rx_overflow_i[i] | rx_bad_token_i[i]) begin
					err_reg[i] <= 1'b1;
				end else if (rxrst_wr[i]) begin
					err_reg[i] <= 1'b0;
				end
			end
		end
	end

	// credit issued to far end; cleared on disable or receiver reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			given_reg <= '0;
		end else begin
			for (int i = 0; i < LINKS; i++) begin
				if (credit_issued_i[i]) begin
					given_reg[i] <= 1'b1;
				end else if (!en_reg[i] || rxrst_wr[i]) begin
					given_reg[i] <= 1'b0;
				end
			end
		end
	end

	// credit held by this end; greeting trigger or disable clears it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_reg <= '0;
		end else begin
			for (int i = 0; i < LINKS; i++) begin
				if (credit_recv_i[i]) begin
					hold_reg[i] <= 1'b1;
				end else if (greet_wr[i] || !en_reg[i]) begin
					hold_reg[i] <= 1'b0;
				end
			end
		end
	end

	// trigger pulses toward the link
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			greeting_o <= '0;
			rx_reset_o <= '0;
		end else begin
			greeting_o <= greet_wr;
			rx_reset_o <= rxrst_wr;
		end
	end

	// link enable, pin mux and width outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_en_o <= '0;
			pin_to_link_o <= '0;
			wide_mode_o <= '0;
		end else begin
			link_en_o <= en_reg;
			pin_to_link_o <= en_reg;
			wide_mode_o <= wide_reg;
		end
	end

	// static forwarding registers, held per link a..h
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fwd_en_reg <= '0;
			fwd_proc_reg <= '0;
			for (int i = 0; i < LINKS; i++) begin
				fwd_chan_reg[i] <= slc_pkg::CHAN_RST;
			end
		end else begin
			for (int i = 0; i < LINKS; i++) begin
				if (fwd_wr[i] && avs_byteenable_i[3]) begin
					fwd_en_reg[i] <= wdata[slc_pkg::FWD_EN_BIT];
				end
				if (fwd_wr[i] && avs_byteenable_i[1]) begin
					fwd_proc_reg[i] <= wdata[slc_pkg::PROC_BIT];
				end
				if (fwd_wr[i] && avs_byteenable_i[0]) begin
					fwd_chan_reg[i] <=
						wdata[slc_pkg::CHAN_LO +: CW];
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fwd_en_o <= '0;
			fwd_proc_o <= '0;
			fwd_chanend_o <= '0;
		end else begin
			for (int i = 0; i < LINKS; i++) begin
				fwd_en_o[i] <= fwd_en_reg[i] & en_reg[i];
				fwd_proc_o[i] <= fwd_proc_reg[i];
				fwd_chanend_o[i*CW +: CW] <= fwd_chan_reg[i];
			end
		end
	end

	// symbol and token pacing per link
	for (genvar g = 0; g < LINKS; g++) begin : g_pace
		slc_tx_pacer #(
			.GAP_W(GW)
		) u_pacer (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.sym_i(tx_sym_i[g]),
			.last_i(tx_tok_end_i[g]),
			.sym_gap_i(sym_gap_reg[g]),
			.tok_gap_i(tok_gap_reg[g]),
			.ready_o(tx_ready_o[g])
		);
	end

	// interrupt status: set wins over read clear
	logic [15:0] irq_evt;
	logic stat_rd;
	assign stat_rd = rd_acc && (avs_address_i == slc_pkg::IRQ_STAT);
	always_comb begin
		irq_evt = '0;
		for (int i = 0; i < LINKS; i++) begin
			irq_evt[i] = (rx_overflow_i[i] | rx_bad_token_i[i]) & ~err_reg[i];
			irq_evt[slc_pkg::IRQ_CRED_LO + i] =
				credit_recv_i[i] & ~hold_reg[i];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat_reg <= slc_pkg::IRQ_RST;
		end else if (stat_rd) begin
			// clear only what the read reported, later events survive
			irq_stat_reg <= (irq_stat_reg & ~avs_readdata_o[15:0]) | irq_evt;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_evt;
		end
	end

	logic [31:0] mask_mrg;
	assign mask_mrg = merge({16'h0, irq_mask_reg}, avs_writedata_i,
		avs_byteenable_i);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_mask_reg <= slc_pkg::IRQ_RST;
		end else if (wr_acc && avs_address_i == slc_pkg::IRQ_MASK) begin
			irq_mask_reg <= mask_mrg[15:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// read data, loaded the cycle waitrequest drops
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < LINKS; i++) begin
			if (avs_address_i == slc_pkg::CTRL_BASE + 8'(i)) begin
				rd_mux[slc_pkg::EN_BIT] = en_reg[i];
				rd_mux[slc_pkg::WIDE_BIT] = wide_reg[i];
				rd_mux[slc_pkg::ERR_BIT] = err_reg[i];
				rd_mux[slc_pkg::GIVEN_BIT] = given_reg[i];
				rd_mux[slc_pkg::HOLD_BIT] = hold_reg[i];
				rd_mux[slc_pkg::SYM_LO +: GW] = sym_gap_reg[i];
				rd_mux[slc_pkg::TOK_LO +: GW] = tok_gap_reg[i];
			end
			if (avs_address_i == slc_pkg::FWD_BASE + 8'(fwd_link(i))) begin
				rd_mux[slc_pkg::FWD_EN_BIT] = fwd_en_reg[i];
				rd_mux[slc_pkg::PROC_BIT] = fwd_proc_reg[i];
				rd_mux[slc_pkg::CHAN_LO +: CW] = fwd_chan_reg[i];
			end
		end
		if (avs_address_i == slc_pkg::IRQ_STAT) begin
			rd_mux[15:0] = irq_stat_reg;
		end
		if (avs_address_i == slc_pkg::IRQ_MASK) begin
			rd_mux[15:0] = irq_mask_reg;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && avs_waitrequest_o) begin
			avs_readdata_o <= rd_mux;
		end
	end
endmodule
`default_nettype wire

// *** core/slc_pkg.sv ***
`default_nettype none
package slc_pkg;
	// sizes
	localparam int LINKS = 8;
	localparam int AW = 8;
	localparam int GAP_W = 11;
	localparam int CHAN_W = 5;
	// register indices (byte address is four times the index)
	localparam logic [7:0] CTRL_BASE = 8'h80;
	localparam logic [7:0] FWD_BASE = 8'ha0;
	localparam logic [7:0] IRQ_STAT = 8'hc0;
	localparam logic [7:0] IRQ_MASK = 8'hc1;
	// control/status fields
	localparam int EN_BIT = 31;
	localparam int WIDE_BIT = 30;
	localparam int ERR_BIT = 27;
	localparam int GIVEN_BIT = 26;
	localparam int HOLD_BIT = 25;
	localparam int GREET_BIT = 24;
	localparam int RXRST_BIT = 23;
	localparam int SYM_LO = 11;
	localparam int TOK_LO = 0;
	// static forwarding fields
	localparam int FWD_EN_BIT = 31;
	localparam int PROC_BIT = 8;
	localparam int CHAN_LO = 0;
	// reset values
	localparam logic EN_RST = 1'b0;
	localparam logic WIDE_RST = 1'b0;
	localparam logic [10:0] GAP_RST = 11'h000;
	localparam logic FWD_EN_RST = 1'b0;
	localparam logic PROC_RST = 1'b0;
	localparam logic [4:0] CHAN_RST = 5'h00;
	localparam logic [15:0] IRQ_RST = 16'h0000;
	// interrupt layout: error per link low, credit gained per link high
	localparam int IRQ_CRED_LO = 8;
endpackage
`default_nettype wire

// *** core/slc_tx_pacer.sv ***
`default_nettype none
module slc_tx_pacer #(
	parameter int GAP_W = 11
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// transmit events
	input wire logic sym_i,
	input wire logic last_i,
	input wire logic [GAP_W-1:0] sym_gap_i,
	input wire logic [GAP_W-1:0] tok_gap_i,
	// permission to send next symbol
	output logic ready_o
);
	logic [GAP_W:0] cnt_reg;
	logic [GAP_W:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (sym_i) begin
			if (last_i) begin
				cnt_next = {1'b0, tok_gap_i} + 1'b1;
			end else begin
				cnt_next = {1'b0, sym_gap_i} + 1'b1;
			end
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ready_o <= 1'b1;
		end else begin
			ready_o <= (cnt_next == '0);
		end
	end
endmodule
`default_nettype wire

// *** test/slc_link_ctrl_chk.sv ***
`default_nettype none
module slc_link_ctrl_chk #(
	parameter int LINKS = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// link side
	input wire logic [LINKS-1:0] tx_sym_i,
	input wire logic [LINKS-1:0] link_en_o,
	input wire logic [LINKS-1:0] pin_to_link_o,
	input wire logic [LINKS-1:0] greeting_o,
	input wire logic [LINKS-1:0] rx_reset_o,
	input wire logic [LINKS-1:0] tx_ready_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic wr0;
	logic rdc;
	logic rdf;
	assign wr0 = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h80;
	assign rdc = avs_read_i && !avs_waitrequest_o &&
		avs_address_i[7:3] == 5'h10;
	assign rdf = avs_read_i && !avs_waitrequest_o &&
		avs_address_i[7:3] == 5'h14;
	a_pins_follow_en: assert property (pin_to_link_o == link_en_o)
		else $error("pin mux differs from enable");
	a_en_written: assert property (wr0 && avs_byteenable_i[3] |->
		##2 link_en_o[0] == $past(avs_writedata_i[31], 2))
		else $error("enable not taken from write");
	a_greet_pulse: assert property (wr0 && avs_byteenable_i[3] &&
		avs_writedata_i[24] |=> greeting_o[0] ##1 !greeting_o[0])
		else $error("greeting pulse wrong");
	a_rxrst_pulse: assert property (wr0 && avs_byteenable_i[2] &&
		avs_writedata_i[23] |=> rx_reset_o[0] ##1 !rx_reset_o[0])
		else $error("receiver reset pulse wrong");
	a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	a_wait_answer: assert property ((avs_read_i || avs_write_i) &&
		avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered");
	a_sym_pace: assert property (tx_sym_i[0] |=> !tx_ready_o[0])
		else $error("no idle after symbol");
	a_ctrl_rsvd: assert property (rdc |-> avs_readdata_o[29:28] == 2'h0 &&
		avs_readdata_o[24:22] == 3'h0)
		else $error("control reserved bits set");
	a_fwd_rsvd: assert property (rdf |-> avs_readdata_o[30:9] == 22'h0 &&
		avs_readdata_o[7:5] == 3'h0)
		else $error("forward reserved bits set");
	c_greet: cover property (wr0 && avs_writedata_i[24]);
	c_fwd_read: cover property (rdf);
	c_paced: cover property ($fell(tx_ready_o[0]));
endmodule
bind slc_link_ctrl slc_link_ctrl_chk #(.LINKS(LINKS)) u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.tx_sym_i(tx_sym_i),
	.link_en_o(link_en_o),
	.pin_to_link_o(pin_to_link_o),
	.greeting_o(greeting_o),
	.rx_reset_o(rx_reset_o),
	.tx_ready_o(tx_ready_o)
);
`default_nettype wire

// *** test/slc_far_end.sv ***
`default_nettype none
module slc_far_end (
	// clock
	input wire logic clk_i,
	// permission from the block
	input wire logic [7:0] tx_ready_i,
	// events: 0 overflow, 1 bad token, 2 credit issued, 3 credit in
	output logic [3:0][7:0] ev_o,
	// symbols
	output logic [7:0] sym_o,
	output logic [7:0] end_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ev_o = '0;
		sym_o = '0;
		end_o = '0;
	end
	task automatic pulse(input int k, input int l);
		@(posedge clk_i);
		ev_o[k][l] <= 1'b1;
		@(posedge clk_i);
		ev_o[k][l] <= 1'b0;
	endtask
	// w counts falling edges waited before the last symbol
	task automatic tok(input int l, input int n, output int w);
		for (int s = 0; s < n; s++) begin
			w = 0;
			do begin
				@(negedge clk_i);
				w++;
			end while (!tx_ready_i[l] && w < 3000);
			@(posedge clk_i);
			sym_o[l] <= 1'b1;
			end_o[l] <= (s == n - 1);
			@(posedge clk_i);
			sym_o[l] <= 1'b0;
			end_o[l] <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// *** test/slc_link_ctrl_bench.sv ***
`default_nettype none
module slc_link_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rq = 1'b0;
	logic wq = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hf;
	logic [31:0] rdata, v;
	logic wait_r, irq;
	logic [3:0][7:0] ev;
	logic [7:0] sym, tend, rdy, en, pins, wide, fen, fproc;
	logic [39:0] fch;
	int err_count = 0;
	int checks = 0;
	int w;
	always #25 clk_i = ~clk_i;
	slc_link_ctrl DUT (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.avs_address_i(adr),
		.avs_read_i(rq),
		.avs_write_i(wq),
		.avs_writedata_i(wd),
		.avs_byteenable_i(be),
		.avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_r),
		.rx_overflow_i(ev[0]),
		.rx_bad_token_i(ev[1]),
		.credit_issued_i(ev[2]),
		.credit_recv_i(ev[3]),
		.tx_sym_i(sym),
		.tx_tok_end_i(tend),
		.link_en_o(en),
		.pin_to_link_o(pins),
		.wide_mode_o(wide),
		.greeting_o(),
		.rx_reset_o(),
		.tx_ready_o(rdy),
		.fwd_en_o(fen),
		.fwd_proc_o(fproc),
		.fwd_chanend_o(fch),
		.irq_o(irq)
	);
	slc_far_end far (
		.clk_i(clk_i),
		.tx_ready_i(rdy),
		.ev_o(ev),
		.sym_o(sym),
		.end_o(tend)
	);
	task automatic report_and_stop();
		if (err_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic acc(input logic r, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		wd <= d;
		be <= b;
		rq <= r;
		wq <= !r;
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_r !== 1'b0 && n < 20);
		v = rdata;
		rq <= 1'b0;
		wq <= 1'b0;
		if (n >= 20) begin
			err_count++;
			report_and_stop();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b1, a, 32'h0, 4'hf);
		chk($sformatf("reg %h", a), e, v);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("outs", 32'h000000ff, {fen, en, wide, rdy});
		for (int i = 0; i < 8; i++) begin
			rc(8'(8'h80 + i), 32'h0);
			rc(8'(8'ha0 + i), 32'h0);
		end
		acc(1'b0, 8'h80, 32'hffffffff, 4'hf);
		rc(8'h80, 32'hc03fffff);
		chk("en pin wide", 32'h010101, {8'h0, en, pins, wide});
		acc(1'b0, 8'h80, 32'h0, 4'h7);
		rc(8'h80, 32'hc0000000);
		acc(1'b0, 8'h80, 32'h80001802, 4'hf);
		rc(8'h80, 32'h80001802);
		chk("wide", 32'h0, {24'h0, wide});
		far.tok(0, 2, w);
		chk("sym gap", 32'd5, 32'(w));
		far.tok(0, 1, w);
		chk("tok gap", 32'd4, 32'(w));
		acc(1'b0, 8'hc1, 32'hffff0101, 4'hf);
		rc(8'hc1, 32'h00000101);
		far.pulse(1, 1);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'h0, {31'h0, irq});
		far.pulse(0, 0);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'h1, {31'h0, irq});
		rc(8'h80, 32'h88001802);
		rc(8'hc0, 32'h00000003);
		repeat (2) @(posedge clk_i);
		chk("irq", 32'h0, {31'h0, irq});
		far.pulse(3, 0);
		far.pulse(2, 0);
		rc(8'h80, 32'h8e001802);
		acc(1'b0, 8'h80, 32'h81000000, 4'h8);
		rc(8'h80, 32'h8c001802);
		acc(1'b0, 8'h80, 32'h00800000, 4'h4);
		rc(8'h80, 32'h80001802);
		rc(8'hc0, 32'h00000100);
		acc(1'b0, 8'h88, 32'hffffffff, 4'hf);
		rc(8'h88, 32'h0);
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, 8'(8'h80 + i), 32'h80000000, 4'h8);
			acc(1'b0, 8'(8'ha0 + i), 32'hfffffee0 | 32'((i & 1) << 8) |
				32'(i + 3), 4'hf);
			rc(8'(8'ha0 + i), 32'h80000000 | 32'((i & 1) << 8) |
				32'(i + 3));
		end
		for (int k = 0; k < 8; k++) begin
			chk("fwd", {22'h0, 1'b1, 1'(k & 1), 3'h0, 5'(k + 3)},
				{22'h0, fen[k ^ 2], fproc[k ^ 2], 3'h0,
				fch[5 * (k ^ 2) +: 5]});
		end
		acc(1'b0, 8'h82, 32'h0, 4'h8);
		repeat (3) @(posedge clk_i);
		chk("fwd en", 32'h000000fb, {24'h0, fen});
		report_and_stop();
	end
endmodule
`default_nettype wire
